// *** rtl/axis_seq_params.svh ***
`ifndef AXIS_SEQ_PARAMS_SVH
`define AXIS_SEQ_PARAMS_SVH
`define SCALE_UNITY        16'h03E8
`define EVT_ENABLE_BIT     12
`define CODE_WAIT_EVENT    8'h05
`define CODE_CAPTURE       8'h07
`define CODE_MOVE_EVT_A    8'h0A
`define CODE_MOVE_EVT_B    8'h0B
`define CODE_NEVER_STOP    8'h15
`define CODE_APPROACH      8'h1E
`define CODE_NON_STEP      8'h20
`define SELFTEST_NS        1000
`define CLK_PERIOD_NS      25
`define SELFTEST_CYCLES    ((`SELFTEST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** rtl/axis_seq_pkg.sv ***
package axis_seq_pkg;
	typedef enum logic [2:0] {
		MODE_SELFTEST = 3'b000,
		MODE_CFGTEST  = 3'b001,
		MODE_MEASURE  = 3'b010,
		MODE_RUN      = 3'b011,
		MODE_STOPPING = 3'b100,
		MODE_FAULT    = 3'b101
	} mode_t;
endpackage

// *** rtl/axis_sequencing_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "axis_seq_params.svh"
module axis_sequencing_mode_control #(
	parameter int SELFTEST_LEN = `SELFTEST_CYCLES,
	parameter int POS_W        = 32
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	// Processor command bits and words
	input  wire logic             step_mode_request,
	input  wire logic             advance_step,
	input  wire logic [15:0]      speed_scale_word,
	input  wire logic             modulo_event_enable,
	input  wire logic             stop_order,
	input  wire logic             plc_run,
	input  wire logic             comm_ok,
	input  wire logic             reconfig_request,
	input  wire logic             config_valid,
	input  wire logic             selftest_error,
	input  wire logic             blocking_fault,
	input  wire logic             auto_mode,
	input  wire logic             unlimited_axis,
	// Trajectory side, same clock
	input  wire logic             move_start,
	input  wire logic [7:0]       move_code,
	input  wire logic [15:0]      move_command,
	input  wire logic             move_stops,
	input  wire logic             move_slaved,
	input  wire logic             move_done,
	input  wire logic             decelerating,
	input  wire logic             target_passed,
	input  wire logic             axis_at_rest,
	input  wire logic [15:0]      programmed_feed,
	input  wire logic [15:0]      approach_feed,
	input  wire logic             evt_detected,
	input  wire logic             wait_done,
	input  wire logic             wait_timeout,
	input  wire logic             capture_done,
	input  wire logic             modulo_crossed,
	input  wire logic [POS_W-1:0] capture_pos_a,
	input  wire logic [POS_W-1:0] capture_pos_b,
	input  wire logic             event_ack,
	// Status and trajectory control
	output logic                  step_mode_active,
	output logic                  force_stop,
	output logic                  step_go,
	output logic [15:0]           feed_out,
	output logic                  feed_hold_active,
	output logic                  abort_move,
	output logic                  decel_request,
	output logic                  outputs_enable,
	output logic                  fault_flag,
	output logic [2:0]            mode_state,
	output logic                  event_request,
	output logic                  move_until_event_done_flag,
	output logic                  wait_event_done_flag,
	output logic                  wait_event_timeout_flag,
	output logic                  position_capture_flag,
	output logic                  modulo_crossing_flag,
	output logic                  event_overrun_flag,
	output logic [POS_W-1:0]      captured_position_first,
	output logic [POS_W-1:0]      captured_position_second
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers for processor bits that arrive asynchronously
// Only the two stepping bits come from the processor's own scan, so only
// they pay the two-flop latency; every other input is already on clk.
// The advance edge is taken after the second flop, never from the first,
// so a metastable first stage can never produce a phantom step.
// The edge register resets low, which matches the idle level of the bit,
// so no false advance follows reset.
// Limitation: an advance pulse shorter than one clock may be missed.
logic [1:0] step_req_sync_reg;
logic [1:0] adv_sync_reg;
logic       adv_prev_reg;
always_ff @(posedge clk) begin
	if (!nrst) begin
		step_req_sync_reg <= 2'h0;
		adv_sync_reg      <= 2'h0;
		adv_prev_reg      <= 1'b0;
	end else begin
		step_req_sync_reg <= {step_req_sync_reg[0], step_mode_request};
		adv_sync_reg      <= {adv_sync_reg[0], advance_step};
		adv_prev_reg      <= adv_sync_reg[1];
	end
end

wire step_req = step_req_sync_reg[1];
wire adv_edge = adv_sync_reg[1] & ~adv_prev_reg; // Level alone never advances

////////////////////////////////////////////////////////////////////////////////
// Operating mode sequencer
// The self-test counter starts at reset and saturates, so the test phase
// lasts a fixed number of cycles unless selftest_error ends it in fault.
// The configuration check takes one cycle: the verdict is a plain level.
// Run is left through a stopping state rather than straight to measurement,
// so the axis is always braked before the outputs are made safe.
// A reconfiguration request still present when the axis comes to rest sends the channel back
// through the configuration test instead of into measurement.
// Fault is sticky; only a new configuration can bring the channel back.
axis_seq_pkg::mode_t mode_reg;
axis_seq_pkg::mode_t mode_next;
logic [15:0]         test_cnt_reg;
wire                 test_over = (test_cnt_reg >= 16'(SELFTEST_LEN - 1));
wire                 leave_run = ~plc_run | ~comm_ok;

// Stop first, test configuration with outputs safe
always_comb begin
	mode_next = mode_reg;
	unique case (mode_reg)
		axis_seq_pkg::MODE_SELFTEST: begin
			if (selftest_error)
				mode_next = axis_seq_pkg::MODE_FAULT;
			else if (test_over)
				mode_next = axis_seq_pkg::MODE_CFGTEST;
		end
		axis_seq_pkg::MODE_CFGTEST:
			mode_next = config_valid ? axis_seq_pkg::MODE_MEASURE : axis_seq_pkg::MODE_FAULT;
		axis_seq_pkg::MODE_MEASURE: begin
			if (reconfig_request)
				mode_next = axis_seq_pkg::MODE_CFGTEST;
			else if (plc_run && comm_ok)
				mode_next = axis_seq_pkg::MODE_RUN;
		end
		axis_seq_pkg::MODE_RUN: begin
			if (leave_run || reconfig_request)
				mode_next = axis_seq_pkg::MODE_STOPPING;
		end
		axis_seq_pkg::MODE_STOPPING: begin
			if (axis_at_rest)
				mode_next = reconfig_request ? axis_seq_pkg::MODE_CFGTEST : axis_seq_pkg::MODE_MEASURE;
		end
		axis_seq_pkg::MODE_FAULT: begin
			if (reconfig_request)
				mode_next = axis_seq_pkg::MODE_CFGTEST;
		end
		default: mode_next = axis_seq_pkg::MODE_FAULT;
	endcase
end

always_ff @(posedge clk) begin
	if (!nrst) begin
		mode_reg     <= axis_seq_pkg::MODE_SELFTEST;
		test_cnt_reg <= 16'h0000;
	end else begin
		mode_reg     <= mode_next;
		test_cnt_reg <= test_over ? test_cnt_reg : test_cnt_reg + 16'h0001;
	end
end

wire running = (mode_reg == axis_seq_pkg::MODE_RUN);
assign mode_state     = mode_reg;
assign outputs_enable = running | (mode_reg == axis_seq_pkg::MODE_STOPPING); // Zero in tests
assign fault_flag     = (mode_reg == axis_seq_pkg::MODE_FAULT);
assign decel_request  = (mode_reg == axis_seq_pkg::MODE_STOPPING);

////////////////////////////////////////////////////////////////////////////////
// Step-by-step sequencing
// Stepping state is only loaded at a move boundary, so a request that
// arrives mid-move leaves that move untouched.
// Removal is honoured at once unless the current move was converted and is
// already braking; then the move is allowed to finish as a stopped step.
// The wait flag holds the trajectory after each finished step until the
// synchronised advance edge arrives; a held-high advance bit does nothing.
// Trade-off: the advance edge is two cycles late, which is far below any
// processor scan time and keeps the edge clean.
logic step_conv_reg;
logic step_wait_reg;
logic step_active_reg;

wire step_kind  = (move_code != `CODE_NON_STEP);
wire conv_needs = ~move_stops & (move_code != `CODE_NEVER_STOP);
wire hold_exit  = step_conv_reg & decelerating;

// Arming only applies at a move boundary so a running move finishes unchanged
always_ff @(posedge clk) begin
	if (!nrst) begin
		step_active_reg <= 1'b0;
		step_conv_reg   <= 1'b0;
		step_wait_reg   <= 1'b0;
	end else begin
		if (move_start) begin
			step_active_reg <= step_req & step_kind;
			step_conv_reg   <= step_req & step_kind & conv_needs;
		end else if (move_done) begin
			step_active_reg <= step_active_reg & step_req;
			step_conv_reg   <= 1'b0;
		end else if (!step_req && !hold_exit) begin
			step_active_reg <= 1'b0;
			step_conv_reg   <= 1'b0;
		end
		if (move_done && step_active_reg && step_req)
			step_wait_reg <= 1'b1;
		else if (adv_edge || !step_req)
			step_wait_reg <= 1'b0;
	end
end

assign step_mode_active = step_active_reg;
assign force_stop       = step_conv_reg;
assign step_go          = ~step_wait_reg | adv_edge;

////////////////////////////////////////////////////////////////////////////////
// Feed hold and speed scaling
// A zero scale word asks for a hold; the trajectory keeps its target and
// only the feed drops, but a move that does not stop is aborted if it passes its target during the hold.
// The hold is dropped by a stop order or a blocking fault even if the
// scale word is still zero.
// Slaved moves ignore the hold: their speed belongs to the master.
// The product is formed at full width before the division by unity so
// no intermediate bits are lost.
// Limitation: a scale above unity can exceed the 16-bit feed range.
logic        hold_reg;
logic [15:0] feed_reg;
wire         hold_cancel = stop_order | blocking_fault;
wire         hold_req    = (speed_scale_word == 16'h0000) & auto_mode & ~move_slaved;
wire [15:0]  base_feed   = (step_conv_reg && move_code == `CODE_APPROACH) ? approach_feed : programmed_feed;
wire [31:0]  scaled      = (32'(base_feed) * 32'(speed_scale_word)) / 32'(`SCALE_UNITY);

always_ff @(posedge clk) begin
	if (!nrst) begin
		hold_reg <= 1'b0;
		feed_reg <= 16'h0000;
	end else begin
		hold_reg <= hold_req & ~hold_cancel & running;
		feed_reg <= (hold_reg || !running) ? 16'h0000 : scaled[15:0]; // Decel to zero
	end
end

assign feed_hold_active = hold_reg;
assign feed_out         = feed_reg;
assign abort_move       = hold_reg & target_passed & ~move_stops;

////////////////////////////////////////////////////////////////////////////////
// Event sources and request
// Instruction events need the enable bit of the move's mode word; the
// modulo event has its own enable and needs an unlimited axis.
// The request stands until the processor acknowledges it.
// The source flags keep the causes of the last event so the handler can
// read them after the request has been acknowledged.
// Captured positions are latched as a pair on the capture event only,
// so both always belong to the same capture.
wire evt_en   = move_command[`EVT_ENABLE_BIT];
wire is_mevt  = (move_code == `CODE_MOVE_EVT_A) || (move_code == `CODE_MOVE_EVT_B);
wire e_mevt   = evt_en & is_mevt & evt_detected;
wire e_wait   = evt_en & (move_code == `CODE_WAIT_EVENT) & wait_done;
wire e_tout   = evt_en & (move_code == `CODE_WAIT_EVENT) & wait_timeout;
wire e_capt   = evt_en & (move_code == `CODE_CAPTURE) & capture_done;
wire e_mod    = unlimited_axis & modulo_event_enable & modulo_crossed;
wire e_any    = e_mevt | e_wait | e_tout | e_capt | e_mod;

logic             evt_pend_reg;
logic             ovr_reg;
logic [4:0]       src_reg;
logic [POS_W-1:0] pos_a_reg;
logic [POS_W-1:0] pos_b_reg;

// A new event before acknowledgment is an overrun; for the request, set wins over ack
always_ff @(posedge clk) begin
	if (!nrst) begin
		evt_pend_reg <= 1'b0;
		ovr_reg      <= 1'b0;
		src_reg      <= 5'h00;
		pos_a_reg    <= '0;
		pos_b_reg    <= '0;
	end else begin
		if (e_any)
			evt_pend_reg <= 1'b1;
		else if (event_ack)
			evt_pend_reg <= 1'b0;
		if (e_any && evt_pend_reg && !event_ack)
			ovr_reg <= 1'b1;
		else if (event_ack)
			ovr_reg <= 1'b0;
		if (e_any)
			src_reg <= {e_mod, e_capt, e_tout, e_wait, e_mevt};
		if (e_capt) begin
			pos_a_reg <= capture_pos_a;
			pos_b_reg <= capture_pos_b;
		end
	end
end

assign event_request              = evt_pend_reg;
assign event_overrun_flag         = ovr_reg;
assign move_until_event_done_flag = src_reg[0];
assign wait_event_done_flag       = src_reg[1];
assign wait_event_timeout_flag    = src_reg[2];
assign position_capture_flag      = src_reg[3];
assign modulo_crossing_flag       = src_reg[4];
assign captured_position_first    = pos_a_reg;
assign captured_position_second   = pos_b_reg;

endmodule
`default_nettype wire

// *** sim/axis_seq_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module axis_seq_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [15:0] speed_scale_word,
	input wire logic        move_slaved,
	input wire logic        auto_mode,
	input wire logic        stop_order,
	input wire logic [15:0] move_command,
	input wire logic [7:0]  move_code,
	input wire logic        capture_done,
	input wire logic        modulo_crossed,
	input wire logic        modulo_event_enable,
	input wire logic        unlimited_axis,
	input wire logic        advance_step,
	input wire logic        step_mode_active,
	input wire logic        step_go,
	input wire logic        feed_hold_active,
	input wire logic        outputs_enable,
	input wire logic        fault_flag,
	input wire logic [2:0]  mode_state,
	input wire logic        event_request,
	input wire logic        position_capture_flag,
	input wire logic        modulo_crossing_flag,
	input wire logic        event_overrun_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Outputs stay safe while self-testing or faulted
	chk_selftest_safe: assert property (mode_state == 3'h0 |-> !outputs_enable) else $error("live in test");
	chk_fault_safe: assert property (fault_flag |-> !outputs_enable) else $error("live in fault");
	// Hold needs a zero scale on a free automatic move
	chk_hold_entry: assert property ($rose(feed_hold_active) |->
		$past(speed_scale_word == 16'h0000 && !move_slaved && auto_mode)) else $error("hold cause");
	chk_hold_cancel: assert property (stop_order |=> !feed_hold_active) else $error("hold kept");
	// Event sources and gating
	chk_capture_event: assert property (capture_done && move_command[12] && move_code == 8'h07
		|=> event_request && position_capture_flag) else $error("capture event");
	chk_event_gate: assert property ($rose(event_request) |->
		$past(move_command[12] || modulo_crossed)) else $error("event gate");
	chk_modulo_event: assert property (modulo_crossed && modulo_event_enable && unlimited_axis
		|=> event_request && modulo_crossing_flag) else $error("modulo event");
	// A step resumes only after an advance edge passes the synchroniser
	chk_step_edge: assert property (step_mode_active && $rose(step_go) |->
		$past(advance_step, 2) || $past(advance_step, 3) || $past(advance_step, 4)) else $error("step edge");
	cover property (feed_hold_active);
	cover property (event_overrun_flag);
	cover property (step_mode_active && !step_go);
endmodule
`default_nettype wire

// *** sim/axis_sequencing_mode_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module axis_sequencing_mode_control_bench;
	logic        clk, nrst, step_mode_request, advance_step, modulo_event_enable, stop_order, plc_run, comm_ok;
	logic        reconfig_request, config_valid, selftest_error, blocking_fault, auto_mode, unlimited_axis, move_start;
	logic        move_stops, move_slaved, move_done, decelerating, target_passed, axis_at_rest, evt_detected;
	logic        wait_done, wait_timeout, capture_done, modulo_crossed, event_ack, slow_ack, step_mode_active, step_go;
	logic        force_stop, feed_hold_active, abort_move, decel_request, outputs_enable, fault_flag, event_request;
	logic        move_until_event_done_flag, wait_event_done_flag, wait_event_timeout_flag, position_capture_flag;
	logic        modulo_crossing_flag, event_overrun_flag;
	logic [2:0]  mode_state;
	logic [7:0]  move_code;
	logic [15:0] speed_scale_word, move_command, programmed_feed, approach_feed, feed_out;
	logic [31:0] capture_pos_a, capture_pos_b, captured_position_first, captured_position_second;
	logic [7:0]  codes [6] = '{8'h0A, 8'h0B, 8'h05, 8'h05, 8'h07, 8'h07};
	logic [4:0]  srcs [6]  = '{5'h10, 5'h10, 5'h08, 5'h04, 5'h02, 5'h02};
	int          fail_count = 0, samples_checked = 0, seed = 73, exp_feed;
	int          scale_q[$];

	axis_sequencing_mode_control #(.SELFTEST_LEN(4)) u_axis_sequencing_mode_control (.*);
	plc_event_model u_plc_event_model (.clk(clk), .event_request(event_request), .slow(slow_ack), .event_ack(event_ack));

	////////////////////////////////////////////////////////////////////////
	// Clock and shared drivers; all stimulus lands on the falling edge
	always #12.5 clk = ~clk;
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wait_mode(input logic [2:0] m);
		for (int i = 0; i < 50 && mode_state !== m; i++) @(negedge clk);
		`CHECK(mode_state, m)
	endtask
	task start_move(input logic [7:0] c, input logic [15:0] m);
		{move_code, move_command, move_start} = {c, m, 1'b1};
		tick(1);
		move_start = 1'b0;
	endtask
	task src_pulse(input logic [4:0] s);
		{evt_detected, wait_done, wait_timeout, capture_done, modulo_crossed} = s;
		tick(1);
		{evt_detected, wait_done, wait_timeout, capture_done, modulo_crossed} = 5'h00;
	endtask
	task end_move();
		move_done = 1'b1;
		tick(1);
		move_done = 1'b0;
	endtask
	task end_of_test();
		if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{nrst, step_mode_request, advance_step, modulo_event_enable, stop_order, plc_run, reconfig_request} = '0;
		{selftest_error, blocking_fault, move_start, move_stops, move_slaved, move_done, decelerating} = '0;
		{target_passed, axis_at_rest, evt_detected, wait_done, wait_timeout, capture_done, modulo_crossed} = '0;
		{slow_ack, clk, capture_pos_a, capture_pos_b, move_code, move_command} = '0;
		{comm_ok, config_valid, auto_mode, unlimited_axis} = 4'hF;
		{speed_scale_word, programmed_feed, approach_feed} = {16'h03E8, 16'h0100, 16'($random(seed))};
		tick(2);
		`CHECK({mode_state, outputs_enable, step_go}, 5'h01)
		nrst = 1'b1;
		wait_mode(3'h2);
		plc_run = 1'b1;
		wait_mode(3'h3);
		// Hold, then resume at the scaled feed; last round is slaved
		for (int i = 0; i < 4; i++) begin
			programmed_feed = 16'($random(seed)) & 16'h7FFF;
			scale_q.push_back(($random(seed) & 32'h07FF) % 2000 + 1);
			{move_slaved, speed_scale_word} = {i == 3, 16'h0000};
			start_move(8'h01, 16'h0000);
			tick(3);
			`CHECK(feed_hold_active, i != 3)
			{move_slaved, speed_scale_word} = {1'b0, 16'(scale_q[0])};
			exp_feed = programmed_feed * scale_q.pop_front() / 1000;
			tick(3);
			`CHECK(feed_out, exp_feed[15:0])
			end_move();
		end
		speed_scale_word = 16'h0000;
		tick(3);
		target_passed = 1'b1;
		tick(1);
		`CHECK(abort_move, 1'b1)
		target_passed = 1'b0;
		stop_order = 1'b1;
		tick(2);
		`CHECK(feed_hold_active, 1'b0)
		{stop_order, speed_scale_word} = {1'b0, 16'h03E8};
		// Every instruction source; the last has its event bit clear
		for (int k = 0; k < 6; k++) begin
			start_move(codes[k], k == 5 ? 16'h0000 : 16'h1000);
			{capture_pos_a, capture_pos_b} = {$random(seed), $random(seed)};
			src_pulse(srcs[k]);
			`CHECK(event_request, k != 5)
			`CHECK({move_until_event_done_flag, wait_event_done_flag, wait_event_timeout_flag, position_capture_flag, modulo_crossing_flag}, srcs[k])
			if (k == 4) `CHECK({captured_position_first, captured_position_second}, {capture_pos_a, capture_pos_b})
			tick(3);
			`CHECK(event_request, 1'b0)
		end
		for (int e = 0; e < 2; e++) begin
			modulo_event_enable = e[0];
			src_pulse(5'h01);
			`CHECK({event_request, modulo_crossing_flag}, {e[0], e[0]})
			tick(3);
		end
		// Slow acknowledge: a second event while unacked is an overrun
		slow_ack = 1'b1;
		start_move(8'h07, 16'h1000);
		src_pulse(5'h02);
		tick(1);
		src_pulse(5'h02);
		`CHECK(event_overrun_flag, 1'b1)
		slow_ack = 1'b0;
		tick(12);
		// Stepping asked mid-move engages at the next move only
		step_mode_request = 1'b1;
		tick(4);
		`CHECK(step_mode_active, 1'b0)
		advance_step = 1'b1;
		end_move();
		start_move(8'h01, 16'h0000);
		tick(3);
		`CHECK({step_mode_active, force_stop}, 2'b11)
		end_move();
		tick(6);
		`CHECK(step_go, 1'b0)
		advance_step = 1'b0;
		tick(3);
		advance_step = 1'b1;
		tick(4);
		`CHECK(step_go, 1'b1)
		start_move(8'h1E, 16'h0000);
		exp_feed = approach_feed * 1000 / 1000;
		tick(3);
		`CHECK({force_stop, feed_out}, {1'b1, exp_feed[15:0]})
		start_move(8'h15, 16'h0000);
		tick(3);
		`CHECK({step_mode_active, force_stop}, 2'b10)
		start_move(8'h20, 16'h0000);
		tick(3);
		`CHECK(step_mode_active, 1'b0)
		start_move(8'h01, 16'h0000);
		step_mode_request = 1'b0;
		tick(4);
		`CHECK(step_mode_active, 1'b0)
		// Link loss stops the axis; a bad reconfiguration faults
		comm_ok = 1'b0;
		wait_mode(3'h4);
		`CHECK(decel_request, 1'b1)
		axis_at_rest = 1'b1;
		wait_mode(3'h2);
		{config_valid, reconfig_request} = 2'b01;
		tick(2);
		reconfig_request = 1'b0;
		wait_mode(3'h5);
		`CHECK({fault_flag, outputs_enable}, 2'b10)
		end_of_test();
	end

	// Watchdog well beyond the expected couple of hundred cycles
	initial begin
		#500000;
		fail_count++;
		end_of_test();
	end
endmodule
bind axis_sequencing_mode_control axis_seq_chk u_axis_seq_chk (.*);
`default_nettype wire

// *** sim/plc_event_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_event_model (
	input  wire logic clk,
	input  wire logic event_request,
	input  wire logic slow,
	output var logic  event_ack
);
	int wait_cnt = 0;
	initial event_ack = 1'b0;
	// One ack pulse per request; slow mode lets a second event overrun the first
	always @(negedge clk) begin
		event_ack <= 1'b0;
		wait_cnt <= 0;
		if (event_request && !event_ack) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= (slow ? 6 : 0)) event_ack <= 1'b1;
		end
	end
endmodule
`default_nettype wire
